/* File: src/acb_aux_bank.v */
// Auxiliary control and pin-select register bank on the special-function bus
module acb_aux_bank #(
    parameter PWM_CHANNELS = 6,
    parameter PRE_WIDTH = 4
) (
    input wire i_mclk,
    input wire i_rst,
    // Special-function register port
    input wire [7:0] i_sfr_addr,
    input wire [3:0] i_page_index,
    input wire i_sfr_wr,
    input wire [7:0] i_sfr_wdata,
    input wire i_sfr_rd,
    output reg [7:0] o_sfr_rdata,
    // Clock sources
    input wire i_ext_clock_mode,
    input wire i_master_clock,
    input wire i_low_speed_rc_osc,
    output reg o_pin_clock_out,
    output reg o_pin_clock_out_en,
    output reg o_pin_clock_fast_drive,
    output reg o_beeper_out,
    output reg o_beeper_out_en,
    // PWM break
    input wire i_pwm_break_event,
    input wire [PWM_CHANNELS-1:0] i_pwm_enable,
    input wire [PWM_CHANNELS-1:0] i_pwm_out,
    input wire [PWM_CHANNELS-1:0] i_pwm_gpio_state,
    output reg [PWM_CHANNELS-1:0] o_pwm_pin,
    output reg o_pwm_break_flag,
    // External interrupts, normalised to active low
    input wire i_ext_irq0_pin,
    input wire i_ext_irq1_pin,
    output reg o_ext_irq0_n,
    output reg o_ext_irq1_n,
    // Data pointer and CRC
    output reg o_data_pointer_select,
    output reg [1:0] o_crc_port_select,
    // Two-wire snoop events
    input wire i_snoop_start,
    input wire i_snoop_stop,
    // Timers
    output reg o_timer0_tick,
    output reg o_timer1_tick,
    output reg o_timer0_low_clock_sel,
    input wire i_timer0_clkout,
    input wire i_timer1_clkout,
    output reg o_timer0_clkout_pin,
    output reg o_timer0_clkout_pin_en,
    output reg o_timer1_clkout_pin,
    output reg o_timer1_clkout_pin_en,
    // Pin routes, one-hot over four candidate pin sets
    input wire i_uart0_pin_select_high,
    output reg [3:0] o_timer0_route,
    output reg [3:0] o_timer1_route,
    output reg [3:0] o_timer2_route,
    output reg [3:0] o_uart0_route,
    output reg [3:0] o_two_wire_route,
    // Capture unit inputs
    input wire i_capture0_pin,
    input wire i_capture0_alt_pin,
    input wire i_capture2_pin,
    input wire i_capture4_pin,
    input wire i_capture4_alt_pin,
    input wire i_timer2_ext_input,
    input wire i_timer3_ext_input,
    output reg o_capture0_in,
    output reg o_capture2_in,
    output reg o_capture4_in,
    output reg [2:0] o_capture_misc_route
);

`include "acb_regs.vh"

    reg [7:0] reg_clkout_irq;
    reg [7:0] reg_dptr_crc;
    reg [7:0] reg_timer_snoop;
    reg [7:0] reg_route0;
    reg [7:0] reg_route1;
    reg [7:0] reg_route2;
    reg [PRE_WIDTH-1:0] prescale;
    reg prescale_tick;
    reg [7:0] next_rdata;

    wire [4:0] mck_count;
    wire [4:0] lrc_count;
    wire wr_clkout = i_sfr_wr && (i_sfr_addr == `ACB_ADDR_CLKOUT_IRQ);
    wire wr_dptr = i_sfr_wr && (i_sfr_addr == `ACB_ADDR_DPTR_CRC);
    wire wr_timer = i_sfr_wr && (i_sfr_addr == `ACB_ADDR_TIMER_SNOOP);
    wire route_hit = (i_sfr_addr == `ACB_ADDR_PIN_ROUTE);
    wire sel_page0 = route_hit && (i_page_index == `ACB_PAGE_ROUTE0);
    wire sel_page1 = route_hit && (i_page_index == `ACB_PAGE_ROUTE1);
    wire sel_page2 = route_hit && (i_page_index == `ACB_PAGE_ROUTE2);
    wire [1:0] pco_sel = reg_clkout_irq[`ACB_PCO_HI:`ACB_PCO_LO];
    wire [1:0] beep_sel = reg_route0[`ACB_BEEP_HI:`ACB_BEEP_LO];
    wire break_flag = reg_clkout_irq[`ACB_BREAK_BIT];
    wire [1:0] uart_sel = {i_uart0_pin_select_high, reg_route0[`ACB_UART_LOW_BIT]};
    wire cap_alt = reg_route2[`ACB_CAP_PIN_BIT];

    acb_edge_div #(
        .WIDTH(5)
    ) u_mck_div (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_level(i_master_clock),
        .o_count(mck_count)
    );

    acb_edge_div #(
        .WIDTH(5)
    ) u_lrc_div (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_level(i_low_speed_rc_osc),
        .o_count(lrc_count)
    );

    // Register writes; hardware-set flags win over a clearing write
    always @(posedge i_mclk) begin
        if (i_rst) begin
            reg_clkout_irq <= `ACB_RESET_VALUE;
            reg_dptr_crc <= `ACB_RESET_VALUE;
            reg_timer_snoop <= `ACB_RESET_VALUE;
            reg_route0 <= `ACB_RESET_VALUE;
            reg_route1 <= `ACB_RESET_VALUE;
            reg_route2 <= `ACB_RESET_VALUE;
        end else begin
            if (wr_clkout) begin
                reg_clkout_irq <= i_sfr_wdata & `ACB_MASK_CLKOUT_IRQ;
            end
            if (i_pwm_break_event) begin
                reg_clkout_irq[`ACB_BREAK_BIT] <= 1'b1;
            end
            if (wr_dptr) begin
                // Reserved positions stored as zero whatever is written
                reg_dptr_crc <= i_sfr_wdata & `ACB_MASK_DPTR_CRC;
            end
            if (wr_timer) begin
                reg_timer_snoop[`ACB_T1_FAST_BIT:`ACB_T0_CKOE_BIT] <=
                    i_sfr_wdata[`ACB_T1_FAST_BIT:`ACB_T0_CKOE_BIT];
                if (!i_sfr_wdata[`ACB_START_BIT]) begin
                    reg_timer_snoop[`ACB_START_BIT] <= 1'b0;
                end
                if (!i_sfr_wdata[`ACB_STOP_BIT]) begin
                    reg_timer_snoop[`ACB_STOP_BIT] <= 1'b0;
                end
            end
            if (i_snoop_start) begin
                reg_timer_snoop[`ACB_START_BIT] <= 1'b1;
            end
            if (i_snoop_stop) begin
                reg_timer_snoop[`ACB_STOP_BIT] <= 1'b1;
            end
            if (i_sfr_wr && sel_page0) begin
                reg_route0 <= i_sfr_wdata & `ACB_MASK_ROUTE0;
            end
            if (i_sfr_wr && sel_page1) begin
                reg_route1 <= i_sfr_wdata & `ACB_MASK_ROUTE1;
            end
            if (i_sfr_wr && sel_page2) begin
                reg_route2 <= i_sfr_wdata & `ACB_MASK_ROUTE2;
            end
        end
    end

    // Read mux; other pages at the shared address belong to other banks
    always @* begin
        next_rdata = `ACB_RESET_VALUE;
        case (i_sfr_addr)
            `ACB_ADDR_CLKOUT_IRQ: next_rdata = reg_clkout_irq;
            `ACB_ADDR_DPTR_CRC: next_rdata = reg_dptr_crc;
            `ACB_ADDR_TIMER_SNOOP: next_rdata = reg_timer_snoop;
            `ACB_ADDR_PIN_ROUTE: begin
                if (sel_page0) begin
                    next_rdata = reg_route0;
                end else if (sel_page1) begin
                    next_rdata = reg_route1;
                end else if (sel_page2) begin
                    next_rdata = reg_route2;
                end
            end
            default: next_rdata = `ACB_RESET_VALUE;
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_sfr_rdata <= `ACB_RESET_VALUE;
        end else if (i_sfr_rd) begin
            o_sfr_rdata <= next_rdata;
        end
    end

    // System clock divided by twelve for timers in slow mode
    always @(posedge i_mclk) begin
        if (i_rst) begin
            prescale <= `ACB_PRESCALE_ZERO;
            prescale_tick <= 1'b0;
        end else begin
            prescale_tick <= (prescale == `ACB_PRESCALE_LAST);
            if (prescale == `ACB_PRESCALE_LAST) begin
                prescale <= `ACB_PRESCALE_ZERO;
            end else begin
                prescale <= prescale + `ACB_PRESCALE_ONE;
            end
        end
    end

    // Registered outputs
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_pin_clock_out <= 1'b0;
            o_pin_clock_out_en <= 1'b0;
            o_pin_clock_fast_drive <= 1'b0;
            o_beeper_out <= 1'b0;
            o_beeper_out_en <= 1'b0;
            o_pwm_break_flag <= 1'b0;
            o_ext_irq0_n <= 1'b1;
            o_ext_irq1_n <= 1'b1;
            o_data_pointer_select <= 1'b0;
            o_crc_port_select <= `ACB_SEL_OFF;
            o_timer0_tick <= 1'b0;
            o_timer1_tick <= 1'b0;
            o_timer0_low_clock_sel <= 1'b0;
            o_timer0_clkout_pin <= 1'b0;
            o_timer0_clkout_pin_en <= 1'b0;
            o_timer1_clkout_pin <= 1'b0;
            o_timer1_clkout_pin_en <= 1'b0;
            o_timer0_route <= 4'h1;
            o_timer1_route <= 4'h1;
            o_timer2_route <= 4'h1;
            o_uart0_route <= 4'h1;
            o_two_wire_route <= 4'h1;
            o_capture0_in <= 1'b0;
            o_capture2_in <= 1'b0;
            o_capture4_in <= 1'b0;
            o_capture_misc_route <= 3'h0;
        end else begin
            // External clock mode keeps the pin as clock input only
            o_pin_clock_out_en <= !i_ext_clock_mode && (pco_sel != `ACB_SEL_OFF);
            case (pco_sel)
                `ACB_SEL_DIV1: o_pin_clock_out <= i_master_clock;
                `ACB_SEL_DIV2: o_pin_clock_out <= mck_count[`ACB_TAP_DIV2];
                `ACB_SEL_DIV4: o_pin_clock_out <= mck_count[`ACB_TAP_DIV4];
                default: o_pin_clock_out <= 1'b0;
            endcase
            o_pin_clock_fast_drive <= reg_clkout_irq[`ACB_FAST_DRIVE_BIT];
            o_beeper_out_en <= (beep_sel != `ACB_SEL_OFF);
            case (beep_sel)
                `ACB_SEL_DIV1: o_beeper_out <= lrc_count[`ACB_TAP_DIV32];
                `ACB_SEL_DIV2: o_beeper_out <= lrc_count[`ACB_TAP_DIV16];
                `ACB_SEL_DIV4: o_beeper_out <= lrc_count[`ACB_TAP_DIV8];
                default: o_beeper_out <= 1'b0;
            endcase
            o_pwm_break_flag <= break_flag;
            // Pin is one of active low when polarity is 0, so xor normalises
            o_ext_irq0_n <= i_ext_irq0_pin ^ reg_clkout_irq[`ACB_IRQ0_POL_BIT];
            o_ext_irq1_n <= i_ext_irq1_pin ^ reg_clkout_irq[`ACB_IRQ1_POL_BIT];
            o_data_pointer_select <= reg_dptr_crc[`ACB_DPS_BIT];
            o_crc_port_select <= reg_dptr_crc[`ACB_CRC_HI:`ACB_CRC_LO];
            o_timer0_tick <= reg_timer_snoop[`ACB_T0_FAST_BIT] | prescale_tick;
            o_timer1_tick <= reg_timer_snoop[`ACB_T1_FAST_BIT] | prescale_tick;
            o_timer0_low_clock_sel <= reg_route0[0];
            o_timer0_clkout_pin_en <= reg_timer_snoop[`ACB_T0_CKOE_BIT];
            o_timer1_clkout_pin_en <= reg_timer_snoop[`ACB_T1_CKOE_BIT];
            o_timer0_clkout_pin <= reg_timer_snoop[`ACB_T0_CKOE_BIT] & i_timer0_clkout;
            o_timer1_clkout_pin <= reg_timer_snoop[`ACB_T1_CKOE_BIT] & i_timer1_clkout;
            o_timer0_route <= 4'h1 << reg_route0[`ACB_TIMER0_PIN_SELECT_HI:`ACB_TIMER0_PIN_SELECT_LO];
            o_timer1_route <= 4'h1 << reg_route1[`ACB_TIMER1_PIN_SELECT_HI:`ACB_TIMER1_PIN_SELECT_LO];
            o_timer2_route <= 4'h1 << reg_route1[`ACB_TIMER2_PIN_SELECT_HI:`ACB_TIMER2_PIN_SELECT_LO];
            o_uart0_route <= 4'h1 << uart_sel;
            o_two_wire_route <= 4'h1 << reg_route0[`ACB_TWI_HI:`ACB_TWI_LO];
            o_capture0_in <= cap_alt ? i_capture0_alt_pin : i_capture0_pin;
            o_capture2_in <= reg_route2[`ACB_CAP2_SEL_BIT] ? i_timer3_ext_input :
                i_capture2_pin;
            if (reg_route2[`ACB_CAP4_SEL_BIT]) begin
                o_capture4_in <= i_timer2_ext_input;
            end else begin
                o_capture4_in <= cap_alt ? i_capture4_alt_pin : i_capture4_pin;
            end
            o_capture_misc_route <= {reg_route2[5], reg_route2[4], reg_route2[1]};
        end
    end

    // Break holds each enabled channel at its port state
    genvar ch;
    generate
        for (ch = 0; ch < PWM_CHANNELS; ch = ch + 1) begin : g_break
            always @(posedge i_mclk) begin
                if (i_rst) begin
                    o_pwm_pin[ch] <= 1'b0;
                end else if (break_flag && i_pwm_enable[ch]) begin
                    o_pwm_pin[ch] <= i_pwm_gpio_state[ch];
                end else begin
                    o_pwm_pin[ch] <= i_pwm_out[ch];
                end
            end
        end
    endgenerate

endmodule // acb_aux_bank

/* File: inc/acb_regs.vh */
// Register map, field positions and constants of the auxiliary control bank
`ifndef ACB_REGS_VH
`define ACB_REGS_VH

`define ACB_ADDR_CLKOUT_IRQ   8'ha1
`define ACB_ADDR_DPTR_CRC     8'ha2
`define ACB_ADDR_TIMER_SNOOP  8'ha3
`define ACB_ADDR_PIN_ROUTE    8'ha4

`define ACB_PAGE_ROUTE0       4'h0
`define ACB_PAGE_ROUTE1       4'h1
`define ACB_PAGE_ROUTE2       4'h2

`define ACB_RESET_VALUE       8'h00

// Implemented bits per register, the rest read as zero
`define ACB_MASK_CLKOUT_IRQ   8'hf3
`define ACB_MASK_DPTR_CRC     8'h31
`define ACB_MASK_TIMER_SNOOP  8'hcf
`define ACB_MASK_ROUTE0       8'hff
`define ACB_MASK_ROUTE1       8'hf0
`define ACB_MASK_ROUTE2       8'hf7

// Clock-out / interrupt polarity register
`define ACB_PCO_HI            7
`define ACB_PCO_LO            6
`define ACB_FAST_DRIVE_BIT    5
`define ACB_BREAK_BIT         4
`define ACB_IRQ1_POL_BIT      1
`define ACB_IRQ0_POL_BIT      0

// Data pointer / CRC register
`define ACB_CRC_HI            5
`define ACB_CRC_LO            4
`define ACB_DPS_BIT           0

// Timer clock / snoop flag register
`define ACB_START_BIT         7
`define ACB_STOP_BIT          6
`define ACB_T1_FAST_BIT       3
`define ACB_T0_FAST_BIT       2
`define ACB_T1_CKOE_BIT       1
`define ACB_T0_CKOE_BIT       0

// Page 0 routing register
`define ACB_TIMER0_PIN_SELECT_HI           7
`define ACB_TIMER0_PIN_SELECT_LO           6
`define ACB_BEEP_HI           5
`define ACB_BEEP_LO           4
`define ACB_UART_LOW_BIT      3
`define ACB_TWI_HI            2
`define ACB_TWI_LO            1

// Page 1 routing register
`define ACB_TIMER2_PIN_SELECT_HI           7
`define ACB_TIMER2_PIN_SELECT_LO           6
`define ACB_TIMER1_PIN_SELECT_HI           5
`define ACB_TIMER1_PIN_SELECT_LO           4

// Page 2 routing register
`define ACB_CAP4_SEL_BIT      7
`define ACB_CAP2_SEL_BIT      6
`define ACB_CAP_PIN_BIT       2

// Two-bit select codes
`define ACB_SEL_OFF           2'h0
`define ACB_SEL_DIV1          2'h1
`define ACB_SEL_DIV2          2'h2
`define ACB_SEL_DIV4          2'h3

// System clock divided by twelve: terminal count of the prescaler
`define ACB_PRESCALE_LAST     4'hb
`define ACB_PRESCALE_ZERO     4'h0
`define ACB_PRESCALE_ONE      4'h1

// Divider stage taps (bit index of the edge counter)
`define ACB_TAP_DIV2          0
`define ACB_TAP_DIV4          1
`define ACB_TAP_DIV8          2
`define ACB_TAP_DIV16         3
`define ACB_TAP_DIV32         4

`endif

/* File: src/acb_edge_div.v */
// Rising-edge counter whose bits give a clock level divided by powers of two
module acb_edge_div #(
    parameter WIDTH = 5
) (
    input wire i_mclk,
    input wire i_rst,
    input wire i_level,
    output reg [WIDTH-1:0] o_count
);

    reg level_q;

    always @(posedge i_mclk) begin
        if (i_rst) begin
            level_q <= 1'b0;
            o_count <= {WIDTH{1'b0}};
        end else begin
            level_q <= i_level;
            // Bit k toggles every 2^k rising edges, giving a divide by 2^(k+1)
            if (i_level && !level_q) begin
                o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // acb_edge_div

/* File: tb/acb_aux_bank_assertions.sv */
// Port-level concurrent checks for the auxiliary control bank
module acb_aux_bank_assertions #(
    parameter int PWM_CHANNELS = 6
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [3:0] i_page_index,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_rd,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic i_ext_clock_mode,
    input wire logic o_pin_clock_out_en,
    input wire logic i_pwm_break_event,
    input wire logic [PWM_CHANNELS-1:0] i_pwm_enable,
    input wire logic [PWM_CHANNELS-1:0] i_pwm_out,
    input wire logic [PWM_CHANNELS-1:0] i_pwm_gpio_state,
    input wire logic [PWM_CHANNELS-1:0] o_pwm_pin,
    input wire logic o_pwm_break_flag,
    input wire logic o_data_pointer_select,
    input wire logic [1:0] o_crc_port_select,
    input wire logic i_snoop_start,
    input wire logic i_snoop_stop,
    input wire logic i_timer0_clkout,
    input wire logic o_timer0_clkout_pin,
    input wire logic o_timer0_clkout_pin_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    unmapped_page_zero_a: assert property (
        i_sfr_rd && i_sfr_addr == 8'ha4 && i_page_index > 4'h2 |=> o_sfr_rdata == 8'h00)
        else $error("route address outside pages 0 to 2 read nonzero");
    dps_follows_write_a: assert property (
        i_sfr_wr && i_sfr_addr == 8'ha2 |-> ##2 o_data_pointer_select == $past(i_sfr_wdata[0], 2))
        else $error("pointer select does not follow write");
    crc_follows_write_a: assert property (
        i_sfr_wr && i_sfr_addr == 8'ha2 |-> ##2 o_crc_port_select == $past(i_sfr_wdata[5:4], 2))
        else $error("crc port select does not follow write");
    break_event_sets_a: assert property (
        i_pwm_break_event |-> ##2 o_pwm_break_flag)
        else $error("break event did not set flag");
    break_blocks_pwm_a: assert property (
        o_pwm_break_flag && $past(o_pwm_break_flag) |->
        ((o_pwm_pin ^ $past(i_pwm_gpio_state)) & $past(i_pwm_enable)) == '0)
        else $error("enabled pwm pin not held at port state during break");
    pwm_passes_a: assert property (
        !o_pwm_break_flag && !$past(o_pwm_break_flag) && !$past(i_rst) |->
        ((o_pwm_pin ^ $past(i_pwm_out)) & $past(i_pwm_enable)) == '0)
        else $error("enabled pwm pin not passing pwm without break");
    start_flag_read_a: assert property (
        i_snoop_start ##1 (i_sfr_rd && i_sfr_addr == 8'ha3) |=> o_sfr_rdata[7])
        else $error("start flag not seen after start event");
    stop_flag_read_a: assert property (
        i_snoop_stop ##1 (i_sfr_rd && i_sfr_addr == 8'ha3) |=> o_sfr_rdata[6])
        else $error("stop flag not seen after stop event");
    clock_input_only_a: assert property (
        i_ext_clock_mode |=> !o_pin_clock_out_en)
        else $error("pin clock driven in external clock mode");
    timer0_clkout_gate_a: assert property (
        !$past(i_rst) && $stable(o_timer0_clkout_pin_en) |->
        o_timer0_clkout_pin == (o_timer0_clkout_pin_en & $past(i_timer0_clkout)))
        else $error("timer0 clock out pin not gated by enable");

    cover property (o_pwm_break_flag);
    cover property (i_sfr_rd && i_sfr_addr == 8'ha4 && i_page_index == 4'h2);
    cover property (o_timer0_clkout_pin);
endmodule // acb_aux_bank_assertions

bind acb_aux_bank acb_aux_bank_assertions #(.PWM_CHANNELS(PWM_CHANNELS)) u_acb_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_page_index(i_page_index),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
    .o_sfr_rdata(o_sfr_rdata), .i_ext_clock_mode(i_ext_clock_mode),
    .o_pin_clock_out_en(o_pin_clock_out_en), .i_pwm_break_event(i_pwm_break_event),
    .i_pwm_enable(i_pwm_enable), .i_pwm_out(i_pwm_out), .i_pwm_gpio_state(i_pwm_gpio_state),
    .o_pwm_pin(o_pwm_pin), .o_pwm_break_flag(o_pwm_break_flag),
    .o_data_pointer_select(o_data_pointer_select), .o_crc_port_select(o_crc_port_select),
    .i_snoop_start(i_snoop_start), .i_snoop_stop(i_snoop_stop),
    .i_timer0_clkout(i_timer0_clkout), .o_timer0_clkout_pin(o_timer0_clkout_pin),
    .o_timer0_clkout_pin_en(o_timer0_clkout_pin_en)
);

/* File: tb/acb_aux_bank_tb_top.sv */
// Self-checking bench for the auxiliary control bank
module acb_aux_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    int fails = 0, check_count = 0, cycles = 0;
    logic brk_on_wr = 1'h0, i_mclk = 1'h0, i_rst = 1'h1, i_sfr_wr = 1'h0, i_sfr_rd = 1'h0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
    logic [3:0] i_page_index = 4'h0;
    logic i_ext_clock_mode = 1'h0, i_master_clock = 1'h0, i_low_speed_rc_osc = 1'h0;
    logic i_pwm_break_event = 1'h0, i_ext_irq0_pin = 1'h1, i_ext_irq1_pin = 1'h1;
    logic [5:0] i_pwm_enable = 6'h00, i_pwm_out = 6'h00, i_pwm_gpio_state = 6'h00, o_pwm_pin;
    logic i_snoop_start = 1'h0, i_snoop_stop = 1'h0, i_uart0_pin_select_high = 1'h0;
    logic i_timer0_clkout = 1'h0, i_timer1_clkout = 1'h0, i_timer2_ext_input = 1'h0;
    logic i_capture0_pin = 1'h0, i_capture0_alt_pin = 1'h0, i_capture2_pin = 1'h0;
    logic i_capture4_pin = 1'h0, i_capture4_alt_pin = 1'h0, i_timer3_ext_input = 1'h0;
    logic o_pin_clock_out, o_pin_clock_out_en, o_pin_clock_fast_drive, o_beeper_out;
    logic o_beeper_out_en, o_pwm_break_flag, o_ext_irq0_n, o_ext_irq1_n, o_data_pointer_select;
    logic [1:0] o_crc_port_select;
    logic o_timer0_tick, o_timer1_tick, o_timer0_low_clock_sel, o_timer0_clkout_pin;
    logic o_timer0_clkout_pin_en, o_timer1_clkout_pin, o_timer1_clkout_pin_en;
    logic [3:0] o_timer0_route, o_timer1_route, o_timer2_route, o_uart0_route, o_two_wire_route;
    logic o_capture0_in, o_capture2_in, o_capture4_in;
    logic [2:0] o_capture_misc_route;

    acb_aux_bank #(.PWM_CHANNELS(6), .PRE_WIDTH(4)) i_dut (.*);

    initial forever #2 i_mclk = ~i_mclk;

    // Oscillator levels toggle every cycle: one rising edge per two cycles
    always @(negedge i_mclk) begin
        i_master_clock <= ~i_master_clock;
        i_low_speed_rc_osc <= ~i_low_speed_rc_osc;
    end

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] d);
        @(negedge i_mclk);
        i_sfr_addr = a;
        i_page_index = pg;
        i_sfr_wdata = d;
        i_sfr_wr = 1'h1;
        i_pwm_break_event = brk_on_wr;
        @(negedge i_mclk);
        i_sfr_wr = 1'h0;
        i_pwm_break_event = 1'h0;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [3:0] pg,
                        input logic [7:0] exp);
        @(negedge i_mclk);
        i_sfr_addr = a;
        i_page_index = pg;
        i_sfr_rd = 1'h1;
        @(negedge i_mclk);
        i_sfr_rd = 1'h0;
        chk(name, o_sfr_rdata, exp);
    endtask

    // Ones written to the start and stop flags read back zero; the break flag reads back one
    task automatic t_regs;
        logic [7:0] adr [7] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha4, 8'ha4, 8'ha4};
        logic [3:0] pg [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h3};
        logic [7:0] msk [7] = '{8'hf3, 8'h31, 8'h0f, 8'hff, 8'hf0, 8'hf7, 8'h00};
        for (int i = 0; i < 7; i++) begin
            rchk("reset value", adr[i], pg[i], 8'h00);
            wr(adr[i], pg[i], adr[i] == 8'ha2 ? 8'h31 : 8'hff);
            rchk("ones readback", adr[i], pg[i], msk[i]);
            wr(adr[i], pg[i], 8'h00);
            rchk("zeros readback", adr[i], pg[i], 8'h00);
        end
        rchk("unmapped", 8'ha0, 4'h0, 8'h00);
    endtask

    task automatic t_dps_irq;
        for (int k = 0; k < 8; k++) begin
            wr(8'ha2, 4'h0, {2'h0, k[1:0], 3'h0, k[0]});
            wr(8'ha1, 4'h0, {6'h00, k[1:0]});
            i_ext_irq0_pin = k[2];
            i_ext_irq1_pin = ~k[2];
            cyc(2);
            chk("pointer select", {7'h00, o_data_pointer_select}, {7'h00, k[0]});
            chk("crc select", {6'h00, o_crc_port_select}, {6'h00, k[1:0]});
            chk("irq0 sense", {7'h00, o_ext_irq0_n}, {7'h00, k[2] ^ k[0]});
            chk("irq1 sense", {7'h00, o_ext_irq1_n}, {7'h00, ~k[2] ^ k[1]});
        end
    endtask

    task automatic t_break;
        i_pwm_enable = 6'h0f;
        i_pwm_out = 6'h2a;
        i_pwm_gpio_state = 6'h15;
        wr(8'ha1, 4'h0, 8'h00);
        cyc(2);
        chk("pwm passes", {2'h0, o_pwm_pin}, 8'h2a);
        i_pwm_break_event = 1'h1;
        cyc(1);
        i_pwm_break_event = 1'h0;
        cyc(3);
        chk("break flag", {7'h00, o_pwm_break_flag}, 8'h01);
        chk("pwm blocked", {2'h0, o_pwm_pin}, 8'h25);
        brk_on_wr = 1'h1;
        wr(8'ha1, 4'h0, 8'h00);
        brk_on_wr = 1'h0;
        rchk("event beats clear", 8'ha1, 4'h0, 8'h10);
        wr(8'ha1, 4'h0, 8'h00);
        rchk("software clear", 8'ha1, 4'h0, 8'h00);
        wr(8'ha1, 4'h0, 8'h10);
        cyc(2);
        chk("software break", {7'h00, o_pwm_break_flag}, 8'h01);
        wr(8'ha1, 4'h0, 8'h00);
    endtask

    task automatic t_snoop;
        i_snoop_start = 1'h1;
        rchk("start only", 8'ha3, 4'h0, 8'h80);
        i_snoop_start = 1'h0;
        i_snoop_stop = 1'h1;
        rchk("both flags", 8'ha3, 4'h0, 8'hc0);
        i_snoop_stop = 1'h0;
        wr(8'ha3, 4'h0, 8'hc0);
        rchk("ones keep flags", 8'ha3, 4'h0, 8'hc0);
        wr(8'ha3, 4'h0, 8'h40);
        rchk("start cleared", 8'ha3, 4'h0, 8'h40);
        wr(8'ha3, 4'h0, 8'h00);
        rchk("stop cleared", 8'ha3, 4'h0, 8'h00);
    endtask

    task automatic t_timer;
        int n0, n1;
        for (int k = 0; k < 2; k++) begin
            wr(8'ha3, 4'h0, k ? 8'h04 : 8'h08);
            cyc(2);
            n0 = 0;
            n1 = 0;
            repeat (24) begin
                @(negedge i_mclk);
                n0 += (o_timer0_tick === 1'h1);
                n1 += (o_timer1_tick === 1'h1);
            end
            chk("timer0 ticks", n0[7:0], k ? 8'h18 : 8'h02);
            chk("timer1 ticks", n1[7:0], k ? 8'h02 : 8'h18);
            i_timer0_clkout = 1'h1;
            i_timer1_clkout = 1'h1;
            wr(8'ha3, 4'h0, k ? 8'h02 : 8'h01);
            cyc(2);
            chk("clock out pins", {4'h0, o_timer1_clkout_pin_en, o_timer1_clkout_pin,
                o_timer0_clkout_pin_en, o_timer0_clkout_pin}, k ? 8'h0c : 8'h03);
        end
    endtask

    task automatic t_clock_out;
        logic [7:0] np, nb;
        logic pp, pb;
        for (int k = 0; k < 4; k++) begin
            wr(8'ha1, 4'h0, {k[1:0], k[0], 5'h00});
            wr(8'ha4, 4'h0, {2'h0, k[1:0], 4'h0});
            cyc(4);
            np = 8'h00;
            nb = 8'h00;
            pp = o_pin_clock_out;
            pb = o_beeper_out;
            repeat (64) begin
                @(negedge i_mclk);
                np += {7'h00, o_pin_clock_out !== pp};
                nb += {7'h00, o_beeper_out !== pb};
                pp = o_pin_clock_out;
                pb = o_beeper_out;
            end
            chk("pin clock toggles", np, k == 0 ? 8'h00 : 8'h80 >> k);
            chk("beeper toggles", nb, k == 0 ? 8'h00 : 8'h01 << k);
            chk("pin clock enable", {6'h00, o_pin_clock_fast_drive, o_pin_clock_out_en},
                {6'h00, k[0], k != 0});
            chk("beeper enable", {7'h00, o_beeper_out_en}, {7'h00, k != 0});
        end
        i_ext_clock_mode = 1'h1;
        cyc(2);
        chk("external clock input", {7'h00, o_pin_clock_out_en}, 8'h00);
        i_ext_clock_mode = 1'h0;
    endtask

    task automatic t_routes;
        for (int k = 0; k < 4; k++) begin
            i_uart0_pin_select_high = k[1];
            wr(8'ha4, 4'h0, {k[1:0], 2'h0, k[0], k[1:0], k[0]});
            wr(8'ha4, 4'h1, {k[1:0], k[1:0], 4'h0});
            cyc(2);
            chk("timer0 route", {3'h0, o_timer0_low_clock_sel, o_timer0_route},
                {3'h0, k[0], 4'h1 << k});
            chk("two wire route", {4'h0, o_two_wire_route}, 8'h01 << k);
            chk("uart0 route", {4'h0, o_uart0_route}, 8'h01 << k);
            chk("timer1 route", {4'h0, o_timer1_route}, 8'h01 << k);
            chk("timer2 route", {4'h0, o_timer2_route}, 8'h01 << k);
        end
    endtask

    // Alt pin differs from timer input to show select priority
    task automatic t_capture;
        logic [7:0] cfg [4] = '{8'h00, 8'h36, 8'hc0, 8'hc4};
        logic [2:0] exp [4] = '{3'h6, 3'h3, 3'h4, 3'h0};
        {i_capture0_pin, i_capture0_alt_pin, i_capture2_pin} = 3'h5;
        {i_capture4_pin, i_capture4_alt_pin, i_timer2_ext_input, i_timer3_ext_input} = 4'h4;
        for (int i = 0; i < 4; i++) begin
            wr(8'ha4, 4'h2, cfg[i]);
            cyc(2);
            chk("capture inputs", {2'h0, o_capture_misc_route, o_capture0_in,
                o_capture2_in, o_capture4_in}, {2'h0, (i == 1 ? 3'h7 : 3'h0), exp[i]});
        end
    endtask

    initial begin
        repeat (2) @(negedge i_mclk);
        i_rst = 1'h0;
        t_regs();
        t_dps_irq();
        t_break();
        t_snoop();
        t_timer();
        t_clock_out();
        t_routes();
        t_capture();
        complete_run();
    end
endmodule // acb_aux_bank_tb_top
